/* rtl/cra_register_array.sv */
// cpu register array: dedicated and working registers, ahb-lite view
// assumes decoder strobes are one-cycle pulses synchronous to clk
//
// Summary of operation
// RULE1 - 16-bit program counter holds fetch address, increments after being driven
// RULE2 - jump, call or return target load beats the increment
// RULE3 - 16-bit stack pointer: decrement before push, increment after pop
// RULE4 - two 16-bit index bases plus signed byte displacement
// RULE5 - vectored pointer: page register high byte, peripheral byte low
// RULE6 - peripheral supplies an even vector byte
// RULE7 - indirect call: low byte from even location, high from next
// RULE8 - 8-bit refresh counter increments after every opcode fetch
// RULE9 - refresh counter goes out on low address with refresh strobe
// RULE10 - instructions can read and write the refresh counter
// RULE11 - six dedicated registers: two 8-bit, four 16-bit
// RULE12 - sixteen 8-bit working registers in main and alternate sets
// RULE13 - only one working set visible; other hidden until exchanged
// RULE14 - first exchange swaps accumulator and flags only
// RULE15 - second exchange swaps the six general bytes only
// RULE16 - accumulator takes alu results and is a general register
// RULE17 - flags hold six status bits, no direct write path
// RULE18 - conditions test only sign, zero, parity/overflow, carry
// RULE19 - refresh strobe low during third and fourth fetch states
// RULE20 - high address carries interrupt page during refresh
// RULE21 - peripheral puts vector low byte out on one acknowledge
// RULE22 - each exchange is atomic, all pairs change together
//
// Implementation choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/10ps
module cra_register_array (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // program counter
   input  wire logic        pcIncr,
   input  wire logic        pcLoad,
   input  wire logic [15:0] pcTarget,
   output logic [15:0]      programCounter,
   // stack pointer and dedicated write/read port
   input  wire logic        spDec,
   input  wire logic        spInc,
   input  wire logic        dedWrEn,
   input  wire logic [2:0]  dedWrSel,
   input  wire logic [15:0] dedWrData,
   input  wire logic [2:0]  dedRdSel,
   output logic [15:0]      dedRdData,
   output logic [15:0]      stackPointer,
   // indexed addressing
   input  wire logic        idxSel,
   input  wire logic [7:0]  displacement,
   output logic [15:0]      indexedAddr,
   // refresh and external address
   input  wire logic        opcodeFetchCycle,
   input  wire logic [1:0]  tState,
   input  wire logic        fetchDone,
   output logic [15:0]      addrOut,
   output logic             refreshStrobeN,
   // vectored interrupt
   input  wire logic        vectorStart,
   input  wire logic [7:0]  vectorByte,
   output logic             vecRdReq,
   output logic [15:0]      vecRdAddr,
   input  wire logic [7:0]  vecRdData,
   input  wire logic        vecRdAck,
   output logic             vecBusy,
   // working registers
   input  wire logic        swapAccumulatorFlags,
   input  wire logic        swapGeneralSets,
   input  wire logic        wrEn,
   input  wire logic [2:0]  wrSel,
   input  wire logic [7:0]  wrData,
   input  wire logic        aluResultEn,
   input  wire logic [7:0]  aluResult,
   input  wire logic        flagsWrEn,
   input  wire logic [7:0]  flagsIn,
   input  wire logic [2:0]  rdSel,
   output logic [7:0]       rdData,
   input  wire logic [1:0]  condSel,
   output logic             condTrue
);
   // ==========================================================
   // storage
   logic [15:0]      pc, sp, ixa, ixb;          // RULE11
   logic [7:0]       ipg, rfc;
   logic [7:0]       wk [16];                   // RULE12
   logic             afBank, gpBank;
   cra_pkg::cra_vec_t vecState;
   logic [7:0]       vecLo, vecHi;
   logic             wrPend;
   logic [7:0]       wrAddr;
   logic             refreshNow;
   logic [7:0]       visFlags;

   // ==========================================================
   // ahb-lite slave: zero wait states, always okay
   logic accept;
   assign accept    = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge clk) begin
      if (srst) begin
         wrPend <= 1'b0;
         wrAddr <= 8'h00;
      end else begin
         wrPend <= accept && hwrite;
         wrAddr <= {haddr[7:2], 2'b00};
      end
   end

   logic busPc, busSp, busIxa, busIxb, busIpg, busRfc, busWk;
   logic [3:0] busPhys;
   assign busPc  = wrPend && wrAddr == cra_pkg::OFS_PC;
   assign busSp  = wrPend && wrAddr == cra_pkg::OFS_SP;
   assign busIxa = wrPend && wrAddr == cra_pkg::OFS_IXA;
   assign busIxb = wrPend && wrAddr == cra_pkg::OFS_IXB;
   assign busIpg = wrPend && wrAddr == cra_pkg::OFS_IPG;
   assign busRfc = wrPend && wrAddr == cra_pkg::OFS_RFC;
   assign busWk  = wrPend && (wrAddr[7:5] == 3'h1 || wrAddr[7:5] == 3'h2);
   // bus sees sets logically: main window is the visible set
   always_comb busPhys = physIdx(wrAddr[4:2], wrAddr[6]);

   function automatic logic [3:0] physIdx(logic [2:0] sel, logic alt);
      logic bank;
      bank = (sel <= cra_pkg::WK_FLG) ? afBank : gpBank;
      return {bank ^ alt, sel};
   endfunction

   function automatic logic [31:0] busRead(logic [7:0] a);
      logic [31:0] r;
      r = 32'h0;
      case (a)
         cra_pkg::OFS_PC:   r = {16'h0, pc};
         cra_pkg::OFS_SP:   r = {16'h0, sp};
         cra_pkg::OFS_IXA:  r = {16'h0, ixa};
         cra_pkg::OFS_IXB:  r = {16'h0, ixb};
         cra_pkg::OFS_IPG:  r = {24'h0, ipg};
         cra_pkg::OFS_RFC:  r = {24'h0, rfc};
         cra_pkg::OFS_STAT: r = {28'h0, vecState, gpBank, afBank};
         default: begin
            if (a[7:5] == 3'h1 || a[7:5] == 3'h2)
               r = {24'h0, wk[physIdx(a[4:2], a[6])]};
         end
      endcase
      return r;
   endfunction

   always_ff @(posedge clk) begin
      if (srst)
         hrdata <= 32'h0;
      else if (accept && !hwrite)
         hrdata <= busRead({haddr[7:2], 2'b00});
   end

   // ==========================================================
   // program counter; bus write wins over all core actions
   always_ff @(posedge clk) begin
      if (srst)
         pc <= cra_pkg::RST_WORD;
      else if (busPc)
         pc <= hwdata[15:0];
      else if (vecState == cra_pkg::VEC_LOAD)
         pc <= {vecHi, vecLo};                  // RULE7
      else if (pcLoad)
         pc <= pcTarget;                        // RULE2
      else if (pcIncr)
         pc <= pc + 16'h1;                      // RULE1
   end

   // ==========================================================
   // stack pointer and index bases
   always_ff @(posedge clk) begin
      if (srst)
         sp <= cra_pkg::RST_WORD;
      else if (busSp)
         sp <= hwdata[15:0];
      else if (dedWrEn && dedWrSel == cra_pkg::DED_SP)
         sp <= dedWrData;
      else if (spDec && !spInc)
         sp <= sp - 16'h1;                      // RULE3
      else if (spInc && !spDec)
         sp <= sp + 16'h1;                      // RULE3
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ixa <= cra_pkg::RST_WORD;
         ixb <= cra_pkg::RST_WORD;
      end else begin
         if (busIxa)
            ixa <= hwdata[15:0];
         else if (dedWrEn && dedWrSel == cra_pkg::DED_IXA)
            ixa <= dedWrData;
         if (busIxb)
            ixb <= hwdata[15:0];
         else if (dedWrEn && dedWrSel == cra_pkg::DED_IXB)
            ixb <= dedWrData;
      end
   end

   always_ff @(posedge clk) begin
      if (srst)
         indexedAddr <= cra_pkg::RST_WORD;
      else
         indexedAddr <= (idxSel ? ixb : ixa)
                      + {{8{displacement[7]}}, displacement}; // RULE4
   end

   // ==========================================================
   // interrupt page and refresh counter
   always_ff @(posedge clk) begin
      if (srst)
         ipg <= cra_pkg::RST_BYTE;
      else if (busIpg)
         ipg <= hwdata[7:0];
      else if (dedWrEn && dedWrSel == cra_pkg::DED_IPG)
         ipg <= dedWrData[7:0];
   end

   // an instruction write replaces the count of the same cycle
   always_ff @(posedge clk) begin
      if (srst)
         rfc <= cra_pkg::RST_BYTE;
      else if (busRfc)
         rfc <= hwdata[7:0];
      else if (dedWrEn && dedWrSel == cra_pkg::DED_RFC)
         rfc <= dedWrData[7:0];                 // RULE10
      else if (fetchDone)
         rfc <= rfc + 8'h1;                     // RULE8
   end

   always_ff @(posedge clk) begin
      if (srst)
         dedRdData <= cra_pkg::RST_WORD;
      else
         case (dedRdSel)
            cra_pkg::DED_SP:  dedRdData <= sp;
            cra_pkg::DED_IXA: dedRdData <= ixa;
            cra_pkg::DED_IXB: dedRdData <= ixb;
            cra_pkg::DED_IPG: dedRdData <= {8'h00, ipg};
            cra_pkg::DED_RFC: dedRdData <= {8'h00, rfc}; // RULE10
            default:          dedRdData <= pc;
         endcase
   end

   // ==========================================================
   // address pins: refresh costs no extra cycle, it shares the fetch
   assign refreshNow = opcodeFetchCycle && tState >= cra_pkg::TST_T3;

   always_ff @(posedge clk) begin
      if (srst) begin
         addrOut        <= cra_pkg::RST_WORD;
         refreshStrobeN <= 1'b1;
      end else begin
         addrOut        <= refreshNow ? {ipg, rfc} : pc; // RULE9 RULE20
         refreshStrobeN <= !refreshNow;                 // RULE19
      end
   end

   // ==========================================================
   // vectored interrupt: fetch the two pointer bytes, then load pc
   assign vecRdReq = vecState == cra_pkg::VEC_LO
                  || vecState == cra_pkg::VEC_HI;
   assign vecBusy  = vecState != cra_pkg::VEC_IDLE;

   always_ff @(posedge clk) begin
      if (srst) begin
         vecState  <= cra_pkg::VEC_IDLE;
         vecRdAddr <= cra_pkg::RST_WORD;
         vecLo     <= cra_pkg::RST_BYTE;
         vecHi     <= cra_pkg::RST_BYTE;
      end else begin
         case (vecState)
            cra_pkg::VEC_IDLE: begin
               if (vectorStart) begin
                  // bit 0 forced low so an odd byte cannot split a pair
                  vecRdAddr <= {ipg, vectorByte[7:1], 1'b0}; // RULE5 RULE6
                  vecState  <= cra_pkg::VEC_LO;
               end
            end
            cra_pkg::VEC_LO: begin
               if (vecRdAck) begin
                  vecLo     <= vecRdData;                    // RULE7
                  vecRdAddr <= vecRdAddr + 16'h1;
                  vecState  <= cra_pkg::VEC_HI;
               end
            end
            cra_pkg::VEC_HI: begin
               if (vecRdAck) begin
                  vecHi    <= vecRdData;                     // RULE7
                  vecState <= cra_pkg::VEC_LOAD;
               end
            end
            default:
               vecState <= cra_pkg::VEC_IDLE;
         endcase
      end
   end

   // ==========================================================
   // working sets: an exchange flips a bank bit, so every pair in the
   // group changes on the same edge and no mix is ever visible
   always_ff @(posedge clk) begin
      if (srst) begin
         afBank <= 1'b0;
         gpBank <= 1'b0;
      end else begin
         if (swapAccumulatorFlags)
            afBank <= !afBank;                  // RULE14 RULE22
         if (swapGeneralSets)
            gpBank <= !gpBank;                  // RULE15 RULE22
      end
   end

   for (genvar e = 0; e < 16; e++) begin : gWk
      localparam logic [2:0] SEL = 3'(e);
      logic vis;
      // bank bits are read inside the function, so a plain assign would
      // never see an exchange; always_comb follows them
      always_comb vis = (physIdx(SEL, 1'b0) == 4'(e)); // RULE13
      always_ff @(posedge clk) begin
         if (srst)
            wk[e] <= cra_pkg::RST_BYTE;
         else if (busWk && busPhys == 4'(e) && SEL != cra_pkg::WK_FLG)
            wk[e] <= hwdata[7:0];
         else if (vis && SEL == cra_pkg::WK_ACC && aluResultEn)
            wk[e] <= aluResult;                 // RULE16
         else if (vis && SEL == cra_pkg::WK_FLG && flagsWrEn)
            wk[e] <= flagsIn & cra_pkg::FLG_MASK; // RULE17
         else if (vis && wrEn && wrSel == SEL && SEL != cra_pkg::WK_FLG)
            wk[e] <= wrData;                    // RULE16
      end
   end

   always_comb visFlags = wk[physIdx(cra_pkg::WK_FLG, 1'b0)];

   always_ff @(posedge clk) begin
      if (srst) begin
         rdData   <= cra_pkg::RST_BYTE;
         condTrue <= 1'b0;
      end else begin
         rdData <= wk[physIdx(rdSel, 1'b0)];    // RULE13
         case (condSel)
            2'h0:    condTrue <= visFlags[cra_pkg::FLG_S];  // RULE18
            2'h1:    condTrue <= visFlags[cra_pkg::FLG_Z];
            2'h2:    condTrue <= visFlags[cra_pkg::FLG_PV];
            default: condTrue <= visFlags[cra_pkg::FLG_C];
         endcase
      end
   end

   assign programCounter = pc;
   assign stackPointer   = sp;

   // ==========================================================
   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   pc_incr_a: assert property (pcIncr && !pcLoad && !busPc // RULE1
      && vecState != cra_pkg::VEC_LOAD |=> pc == $past(pc) + 16'h1)
      else $error("pc did not step");
   pc_load_a: assert property (pcLoad && !busPc            // RULE2
      && vecState != cra_pkg::VEC_LOAD |=> pc == $past(pcTarget))
      else $error("jump target not loaded");
   sp_push_a: assert property (spDec && !spInc && !busSp   // RULE3
      && !(dedWrEn && dedWrSel == cra_pkg::DED_SP)
      |=> sp == $past(sp) - 16'h1)
      else $error("stack pointer did not decrement");
   idx_addr_a: assert property (##1 indexedAddr ==         // RULE4
      $past(idxSel ? ixb : ixa) + {{8{$past(displacement[7])}},
      $past(displacement)})
      else $error("indexed address wrong");
   vec_ptr_a: assert property (vecState == cra_pkg::VEC_IDLE // RULE5
      && vectorStart |=> vecRdAddr == {$past(ipg),
      $past(vectorByte[7:1]), 1'b0} && vecRdAddr[0] == 1'b0)
      else $error("vector pointer wrong");
   vec_call_a: assert property (vecState == cra_pkg::VEC_HI  // RULE7
      && vecRdAck && !busPc ##1 !busPc
      |=> pc == {$past(vecRdData, 2), $past(vecLo)})
      else $error("service address not loaded");
   rfc_step_a: assert property (fetchDone && !busRfc        // RULE8
      && !dedWrEn |=> rfc == $past(rfc) + 8'h1)
      else $error("refresh counter did not step");
   refresh_strobe_pins_a: assert property (refreshNow |=>              // RULE19
      !refreshStrobeN && addrOut == {$past(ipg), $past(rfc)})
      else $error("refresh address or strobe wrong");
   xchg_af_a: assert property (swapAccumulatorFlags         // RULE14
      && !swapGeneralSets |=> afBank != $past(afBank)
      && gpBank == $past(gpBank))
      else $error("accumulator exchange wrong");
   xchg_gp_a: assert property (swapGeneralSets               // RULE15
      && !swapAccumulatorFlags |=> gpBank != $past(gpBank)
      && afBank == $past(afBank))
      else $error("general exchange wrong");
   flg_bits_a: assert property ((visFlags & ~cra_pkg::FLG_MASK) // RULE17
      == 8'h00)
      else $error("flag register holds more than six bits");
   cond_a: assert property (condSel == 2'h1                  // RULE18
      |=> condTrue == $past(visFlags[cra_pkg::FLG_Z]))
      else $error("zero condition wrong");

   vec_seq_c: cover property (vecState == cra_pkg::VEC_IDLE
      && vectorStart ##[1:20] vecState == cra_pkg::VEC_LOAD);
   xchg_c: cover property (swapAccumulatorFlags && swapGeneralSets);
   refresh_strobe_c: cover property (refreshNow ##1 refreshNow && fetchDone);
   jump_c: cover property (pcLoad && pcIncr);
endmodule

/* rtl/cra_pkg.sv */
// constants shared by the cpu register array and its bench
// assumes a 32-bit ahb-lite slave view and one cpu clock
package cra_pkg;
   // ==========================================================
   // bus map, byte addresses within the slave's window
   localparam logic [7:0] OFS_PC      = 8'h00;
   localparam logic [7:0] OFS_SP      = 8'h04;
   localparam logic [7:0] OFS_IXA     = 8'h08;
   localparam logic [7:0] OFS_IXB     = 8'h0c;
   localparam logic [7:0] OFS_IPG     = 8'h10;
   localparam logic [7:0] OFS_RFC     = 8'h14;
   localparam logic [7:0] OFS_STAT    = 8'h18;
   localparam logic [7:0] OFS_WK_MAIN = 8'h20;
   localparam logic [7:0] OFS_WK_ALT  = 8'h40;
   // ==========================================================
   // working register selectors; 2..7 are the six general bytes
   localparam logic [2:0] WK_ACC = 3'h0;
   localparam logic [2:0] WK_FLG = 3'h1;
   // dedicated register selectors for the core write/read port
   localparam logic [2:0] DED_SP  = 3'h0;
   localparam logic [2:0] DED_IXA = 3'h1;
   localparam logic [2:0] DED_IXB = 3'h2;
   localparam logic [2:0] DED_IPG = 3'h3;
   localparam logic [2:0] DED_RFC = 3'h4;
   // ==========================================================
   // flag layout
   localparam int         FLG_C    = 0;
   localparam int         FLG_N    = 1;
   localparam int         FLG_PV   = 2;
   localparam int         FLG_H    = 4;
   localparam int         FLG_Z    = 6;
   localparam int         FLG_S    = 7;
   localparam logic [7:0] FLG_MASK = 8'hd7;
   // ==========================================================
   // reset values and fetch states
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [1:0]  TST_T3   = 2'h2;
   typedef enum logic [1:0] {
      VEC_IDLE = 2'b00,
      VEC_LO   = 2'b01,
      VEC_HI   = 2'b11,
      VEC_LOAD = 2'b10
   } cra_vec_t;
endpackage

/* sim/cra_vec_mem.sv */
// vector table memory on the far side of the vectored-call port
// assumes the register array holds vecRdReq until it sees vecRdAck
`timescale 1ns/10ps
module cra_vec_mem (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // table read port
   input  wire logic        vecRdReq,
   input  wire logic [15:0] vecRdAddr,
   output logic [7:0]       vecRdData,
   output logic             vecRdAck,
   // answer delay in cycles
   input  wire logic [1:0]  ackDelay
);
   // ==========================================================
   // contents follow from the address so the bench can predict them
   logic [1:0] waitCnt;
   always_ff @(posedge clk) begin
      if (srst) begin
         vecRdAck  <= 1'b0;
         vecRdData <= 8'h00;
         waitCnt   <= 2'h0;
      end else if (vecRdReq && !vecRdAck && waitCnt == ackDelay) begin
         vecRdAck  <= 1'b1;
         vecRdData <= vecRdAddr[7:0] + vecRdAddr[15:8] + 8'h3c;
         waitCnt   <= 2'h0;
      end else begin
         // byte is only valid under its one strobe: scramble otherwise
         vecRdAck  <= 1'b0;
         vecRdData <= ~vecRdData;
         waitCnt   <= (vecRdReq && !vecRdAck) ? waitCnt + 2'h1 : 2'h0;
      end
   end
endmodule

/* sim/tb_top.sv */
// self-checking bench for the cpu register array
// assumes cra_pkg, the register array and the vector memory model
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
n_mismatch++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb_top;
   // ==========================================================
   // signals
   logic        clk, srst, hsel, hwrite, hready, hreadyout, hresp;
   logic        pcIncr, pcLoad, spDec, spInc, dedWrEn, idxSel, fetchDone;
   logic        opcodeFetchCycle, refreshStrobeN, vectorStart, vecRdReq;
   logic        vecRdAck, vecBusy, swapAccumulatorFlags, swapGeneralSets;
   logic        wrEn, aluResultEn, flagsWrEn, condTrue;
   logic [1:0]  htrans, tState, condSel, ackDelay;
   logic [2:0]  hsize, dedWrSel, dedRdSel, wrSel, rdSel;
   logic [7:0]  displacement, vectorByte, vecRdData, wrData, aluResult;
   logic [7:0]  flagsIn, rdData, t8, vis [8], hid [8];
   logic [15:0] pcTarget, programCounter, dedWrData, dedRdData, e16;
   logic [15:0] stackPointer, indexedAddr, addrOut, vecRdAddr, ded [6];
   logic [31:0] haddr, hwdata, hrdata, rd;
   int          compares, n_mismatch, seed, i, j, k, n;
   int          condBit [4];
   assign hready = hreadyout;
   always #50 clk = ~clk;
   // ==========================================================
   // design and far side
   cra_register_array dut_u (
      .clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hreadyout, .hresp, .hrdata, .pcIncr, .pcLoad, .pcTarget,
      .programCounter, .spDec, .spInc, .dedWrEn, .dedWrSel, .dedWrData,
      .dedRdSel, .dedRdData, .stackPointer, .idxSel, .displacement,
      .indexedAddr, .opcodeFetchCycle, .tState, .fetchDone, .addrOut,
      .refreshStrobeN, .vectorStart, .vectorByte, .vecRdReq, .vecRdAddr,
      .vecRdData, .vecRdAck, .vecBusy, .swapAccumulatorFlags,
      .swapGeneralSets, .wrEn, .wrSel, .wrData, .aluResultEn, .aluResult,
      .flagsWrEn, .flagsIn, .rdSel, .rdData, .condSel, .condTrue
   );
   cra_vec_mem vmem_u (
      .clk, .srst, .vecRdReq, .vecRdAddr, .vecRdData, .vecRdAck, .ackDelay
   );
   // ==========================================================
   // helpers
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic wait_rdy();
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hready !== 1'b1 && k < 20);
      if (hready !== 1'b1) begin
         n_mismatch++;
         close_out();
      end
   endtask
   // one single word transfer; read data is taken at the data phase edge
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] a,
                         input logic [31:0] ex);
      bus(1'b0, a, 32'h0);
      `CHK(nm, ex, rd)
      `CHK("resp", 1'b0, hresp)
   endtask
   task automatic sync(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   // swap models the exchange on the bench side, trading vis and hid from lo to hi
   task automatic swap(input int lo, input int hi);
      for (int m = lo; m <= hi; m++) begin
         t8 = vis[m];
         vis[m] = hid[m];
         hid[m] = t8;
      end
   endtask
   task automatic chk_sets();
      logic [7:0] a;
      for (int m = 0; m < 8; m++) begin
         a = 8'(4 * m);
         rd_chk("vis", cra_pkg::OFS_WK_MAIN + a, {24'h0, vis[m]});
         rd_chk("hid", cra_pkg::OFS_WK_ALT + a, {24'h0, hid[m]});
      end
   endtask
   function automatic logic [7:0] vexp(input logic [15:0] p);
      return p[7:0] + p[15:8] + 8'h3c;
   endfunction
   // ==========================================================
   // main sequence
   initial begin
      {clk, hsel, hwrite, pcIncr, pcLoad, spDec, spInc, dedWrEn} = '0;
      {idxSel, fetchDone, opcodeFetchCycle, vectorStart, wrEn} = '0;
      {swapAccumulatorFlags, swapGeneralSets, aluResultEn, flagsWrEn} = '0;
      {htrans, tState, condSel, ackDelay, dedWrSel, dedRdSel} = '0;
      {wrSel, rdSel, displacement, vectorByte, wrData, aluResult} = '0;
      {flagsIn, pcTarget, dedWrData, haddr, hwdata, compares} = '0;
      n_mismatch = 0;
      vis = '{default: 8'h00};
      hid = '{default: 8'h00};
      condBit = '{cra_pkg::FLG_S, cra_pkg::FLG_Z, cra_pkg::FLG_PV,
                  cra_pkg::FLG_C};
      srst = 1'b1;
      hsize = 3'h2;
      seed = 45;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      for (i = 0; i < 6; i++) begin
         rd_chk("ded reset", 8'(4 * i), 32'h0);
         rd = $random(seed);
         ded[i] = (i >= 4) ? {8'h00, rd[7:0]} : rd[15:0];
         bus(1'b1, 8'(4 * i), rd);
         rd_chk("ded width", 8'(4 * i), {16'h0, ded[i]});
      end
      n = ($random(seed) & 7) + 2;
      @(posedge clk);
      pcIncr <= 1'b1;
      repeat (n) @(posedge clk);
      pcIncr <= 1'b0;
      #1;
      `CHK("pc step", ded[0] + 16'(n), programCounter)
      @(posedge clk);
      pcTarget <= 16'($random(seed));
      pcLoad <= 1'b1;
      pcIncr <= 1'b1;
      dedRdSel <= cra_pkg::DED_IXB;
      @(posedge clk);
      pcLoad <= 1'b0;
      pcIncr <= 1'b0;
      sync(1);
      `CHK("pc load", pcTarget, programCounter)
      `CHK("ded port", ded[3], dedRdData)
      @(posedge clk);
      spDec <= 1'b1;
      repeat (n) @(posedge clk);
      spInc <= 1'b1;
      @(posedge clk);
      spDec <= 1'b0;
      sync(0);
      `CHK("sp push", ded[1] - 16'(n), stackPointer)
      repeat (n) @(posedge clk);
      spInc <= 1'b0;
      sync(1);
      `CHK("sp pop", ded[1], stackPointer)
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         t8 = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : 8'($random(seed));
         idxSel <= i[0];
         displacement <= t8;
         sync(2);
         e16 = ded[2 + i % 2] + {{8{t8[7]}}, t8};
         `CHK("indexed", e16, indexedAddr)
      end
      $display("test dedicated ended, %0d compares", compares);
      t8 = ded[5][7:0] + 8'h01;
      @(posedge clk);
      fetchDone <= 1'b1;
      repeat (257) @(posedge clk);
      fetchDone <= 1'b0;
      rd_chk("rfc wrap", cra_pkg::OFS_RFC, {24'h0, t8});
      @(posedge clk);
      fetchDone <= 1'b1;
      dedWrEn <= 1'b1;
      dedWrSel <= cra_pkg::DED_RFC;
      dedWrData <= 16'h0055;
      @(posedge clk);
      fetchDone <= 1'b0;
      dedWrEn <= 1'b0;
      rd_chk("rfc write", cra_pkg::OFS_RFC, 32'h55);
      for (i = 0; i < 5; i++) begin
         @(posedge clk);
         opcodeFetchCycle <= (i < 4);
         tState <= (i < 4) ? 2'(i) : 2'h3;
         sync(2);
         e16 = (i == 2 || i == 3) ? {ded[4][7:0], 8'h55} : pcTarget;
         `CHK("addr out", e16, addrOut)
         `CHK("refresh_strobe strobe", !(i == 2 || i == 3), refreshStrobeN)
      end
      for (i = 0; i < 2; i++) begin
         @(posedge clk);
         ackDelay <= 2'(2 * i);
         t8 = 8'($random(seed)) & 8'hfe;
         e16 = {ded[4][7:0], t8};
         vectorStart <= 1'b1;
         vectorByte <= t8;
         @(posedge clk);
         vectorStart <= 1'b0;
         k = 0;
         do begin
            sync(1);
            k++;
         end while (vecBusy !== 1'b0 && k < 40);
         if (vecBusy !== 1'b0) begin
            n_mismatch++;
            close_out();
         end
         `CHK("vector pc", {vexp(e16 + 16'h1), vexp(e16)}, programCounter)
      end
      $display("test refresh and vector ended, %0d compares", compares);
      for (i = 0; i < 8; i++) begin
         @(posedge clk);
         t8 = 8'($random(seed));
         wrEn <= 1'b1;
         wrSel <= 3'(i);
         wrData <= t8;
         if (i != 1) vis[i] = t8;
      end
      @(posedge clk);
      t8 = 8'($random(seed));
      wrEn <= 1'b0;
      flagsWrEn <= 1'b1;
      flagsIn <= 8'hff;
      aluResultEn <= 1'b1;
      aluResult <= t8;
      vis[0] = t8;
      vis[1] = cra_pkg::FLG_MASK;
      @(posedge clk);
      flagsWrEn <= 1'b0;
      aluResultEn <= 1'b0;
      bus(1'b1, cra_pkg::OFS_WK_MAIN + 8'h04, 32'h0);
      rdSel <= 3'h5;
      sync(2);
      `CHK("rd port", vis[5], rdData)
      chk_sets();
      for (i = 0; i < 2; i++) begin
         @(posedge clk);
         swapAccumulatorFlags <= (i == 0);
         swapGeneralSets <= (i == 1);
         @(posedge clk);
         swapAccumulatorFlags <= 1'b0;
         swapGeneralSets <= 1'b0;
         swap(i * 2, i * 6 + 1);
         chk_sets();
         rd_chk("banks", cra_pkg::OFS_STAT, 32'(2 * i + 1));
      end
      for (i = 0; i < 2; i++) begin
         @(posedge clk);
         t8 = (i == 0) ? 8'h12 : 8'($random(seed));
         flagsWrEn <= 1'b1;
         flagsIn <= t8;
         @(posedge clk);
         flagsWrEn <= 1'b0;
         for (j = 0; j < 4; j++) begin
            @(posedge clk);
            condSel <= 2'(j);
            sync(2);
            `CHK("cond", t8[condBit[j]], condTrue)
         end
      end
      rd_chk("unmapped", 8'h1c, 32'h0);
      $display("test working sets ended, %0d compares", compares);
      close_out();
   end
endmodule
